// ### core/timer_defines.svh
/*
 Constants of the triple timer/event counter: register offsets, control
 field positions, encodings, reset values and counter tops.
 Assumes an 8-bit register port with byte-wide offsets.
*/
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// register offsets
`define ADDR_GC 8'h09
`define ADDR_C0_COUNT 8'h0d
`define ADDR_C0_CTRL 8'h0e
`define ADDR_C1_HIGH 8'h0f
`define ADDR_C1_LOW 8'h10
`define ADDR_C1_CTRL 8'h11
`define ADDR_C2_HIGH 8'h1a
`define ADDR_C2_LOW 8'h1b
`define ADDR_C2_CTRL 8'h1c

// control register fields
`define CTRL_PSC_LSB 0
`define CTRL_PSC_MSB 2
`define CTRL_EDGE 3
`define CTRL_RUN 4
`define CTRL_CLKSEL 5
`define CTRL_MODE_LSB 6
`define CTRL_MODE_MSB 7
`define CTRL_RESET 8'h08
`define CTRL_RUN_MASK 8'h10

// mode encodings
`define MODE_UNUSED 2'h0
`define MODE_EVENT 2'h1
`define MODE_TIMER 2'h2
`define MODE_PULSE 2'h3

// general control fields
`define GC_LFS 0
`define GC_TCK_LO 1
`define GC_TCK_HI 2
`define GC_RESET 8'h00

// counter tops and divider
`define TOP_8 16'h00ff
`define TOP_16 16'hffff
`define DIV4_LAST 2'h3

// synchroniser lanes
`define SYN_RC 0
`define SYN_XT 1
`define SYN_REF 2
`define SYN_SEN 3
`define SYN_TMCK 4
`define SYN_PIN 5

`endif

// ### core/timer_pkg.sv
/*
 Types of the triple timer/event counter.
 Assumes nothing of its surroundings.
*/
package timer_pkg;
  typedef enum logic {PW_WAIT, PW_COUNT} pw_state_t;
endpackage

// ### core/triple_timer_event_counter.sv
/*
 Three count-up timer/event counters (8, 16, 16 bits) with prescalers,
 pulse width measurement and buffered 16-bit count access.
 Assumes one 25 MHz system clock; low-frequency, touch and pin inputs are
 asynchronous and far slower than the system clock.
*/
// Operation
// - counter 0 counts 8 bits from pin or system/low-frequency clock
// - counter 1 counts 16 bits from pin or system/4 or low-frequency clock
// - low-frequency clock picks RC oscillator or crystal by one general bit
// - counter 2 counts 16 bits from pin or system/4 or auxiliary clock
// - auxiliary clock picks low-frequency or one of three touch clocks
// - counter 0 count write loads start value, read returns count
// - 16-bit low byte write only fills the low-byte buffer
// - 16-bit high byte write moves high and buffered low into preload
// - 16-bit high byte read returns high half, captures low half
// - 16-bit low byte read returns the low-byte buffer
// - counter 2 count bytes behave exactly like counter 1
// - control bits 2:0 divide the internal clock by 1 to 128
// - event mode: edge bit one counts falling, zero counts rising edges
// - pulse mode: edge bit one measures high level, zero measures low
// - control bit 4 enables counting
// - counter 0 bit 5 picks system clock or low-frequency clock
// - counter 1 bit 5 picks system clock/4 or low-frequency clock
// - bits 7:6 pick event, timer, pulse width or unused mode
// - past the top the counter reloads preload and flags overflow
// - pulse mode clears enable after one measurement, holding the count
// - preload write also loads counter only while it is off
// - reading a count register blocks counting for that access
`timescale 1ns/1ps
`include "timer_defines.svh"

module triple_timer_event_counter (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic internal_low_freq_rc_i,
  input wire logic external_low_freq_crystal_i,
  input wire logic touch_reference_clock_i,
  input wire logic touch_sense_clock_i,
  input wire logic touch_module_clock_i,
  input wire logic [2:0] counter_pin_i,
  output logic [2:0] overflow_o
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [15:0] count_reg [3];
  logic [15:0] preload_reg [3];
  logic [7:0] lowbuf_reg [3];
  logic [7:0] ctrl_reg [3];
  logic [6:0] psc_reg [3];
  timer_pkg::pw_state_t pw_reg [3];
  logic ovf_reg [3];
  logic [7:0] gc_reg;
  logic [1:0] div4_reg;
  logic [7:0] rdata_reg;
  logic [7:0] syn1_reg;
  logic [7:0] syn2_reg;
  logic [7:0] syn3_reg;
  logic [7:0] lvl_reg;
  logic inc_w [3];
  logic top_w [3];
  logic [7:0] rd_val [3];

  // prescaler hit: one tick every 2^sel source ticks
  function automatic logic presc_hit(input logic [6:0] cnt, input logic [2:0] sel);
    logic [6:0] mask;
    mask = 7'((8'h01 << sel) - 8'h01);
    presc_hit = ((cnt & mask) == mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: an edge counts once stages two and three agree
  wire [7:0] async_in = {counter_pin_i, touch_module_clock_i,
    touch_sense_clock_i, touch_reference_clock_i,
    external_low_freq_crystal_i, internal_low_freq_rc_i};
  wire [7:0] settle = ~(syn2_reg ^ syn3_reg) & (syn3_reg ^ lvl_reg);
  wire [7:0] rise = settle & syn3_reg;
  wire [7:0] fall = settle & ~syn3_reg;

  // filter stages; a pin high out of reset shows as one rising edge
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      syn1_reg <= 8'h00;
      syn2_reg <= 8'h00;
      syn3_reg <= 8'h00;
      lvl_reg <= 8'h00;
    end else begin
      syn1_reg <= async_in;
      syn2_reg <= syn1_reg;
      syn3_reg <= syn2_reg;
      lvl_reg <= (syn2_reg & ~(syn2_reg ^ syn3_reg)) | (lvl_reg & (syn2_reg ^ syn3_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock sources: low-frequency for all counters, divide by four for counters 1 and 2, auxiliary for counter 2
  wire lf_tick = gc_reg[`GC_LFS] ? rise[`SYN_XT] : rise[`SYN_RC];
  wire [1:0] tck_sel = {gc_reg[`GC_TCK_HI], gc_reg[`GC_TCK_LO]};
  wire [3:0] aux_srcs = {rise[`SYN_TMCK], rise[`SYN_SEN], rise[`SYN_REF], lf_tick};
  wire aux_tick = aux_srcs[tck_sel];
  wire div4_tick = (div4_reg == `DIV4_LAST);
  wire gc_hit = (addr_i == `ADDR_GC);
  wire [7:0] gc_next = (wr_i && gc_hit) ? wdata_i : gc_reg;

  // free-running divide by four and general control
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div4_reg <= 2'h0;
      gc_reg <= `GC_RESET;
    end else begin
      div4_reg <= 2'(div4_reg + 2'h1);
      gc_reg <= gc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the three counters
  for (genvar i = 0; i < 3; i++) begin : g_cnt
    localparam logic [7:0] A_HI = (i == 0) ? `ADDR_C0_COUNT :
      (i == 1) ? `ADDR_C1_HIGH : `ADDR_C2_HIGH;
    localparam logic [7:0] A_LO = (i == 1) ? `ADDR_C1_LOW : `ADDR_C2_LOW;
    localparam logic [7:0] A_CT = (i == 0) ? `ADDR_C0_CTRL :
      (i == 1) ? `ADDR_C1_CTRL : `ADDR_C2_CTRL;
    localparam logic [15:0] TOP = (i == 0) ? `TOP_8 : `TOP_16;

    // decode and control fields
    wire hit_hi = (addr_i == A_HI);
    wire hit_lo = (i != 0) && (addr_i == A_LO);
    wire hit_ct = (addr_i == A_CT);
    wire [1:0] mode = ctrl_reg[i][`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    wire run = ctrl_reg[i][`CTRL_RUN];
    wire esel = ctrl_reg[i][`CTRL_EDGE];
    wire csel = ctrl_reg[i][`CTRL_CLKSEL];
    wire [2:0] psel = ctrl_reg[i][`CTRL_PSC_MSB:`CTRL_PSC_LSB];

    // internal source: counter 0 runs on every system cycle when not divided
    wire sys_src = (i == 0) ? 1'b1 : div4_tick;
    wire alt_src = (i == 2) ? aux_tick : lf_tick;
    wire src = csel ? alt_src : sys_src;
    wire tick = src && presc_hit(psc_reg[i], psel);

    // pin edges per mode
    wire p_rise = rise[`SYN_PIN + i];
    wire p_fall = fall[`SYN_PIN + i];
    wire ev_edge = esel ? p_fall : p_rise;
    wire pw_start = esel ? p_rise : p_fall;
    wire pw_stop = esel ? p_fall : p_rise;
    wire pw_on = (pw_reg[i] == timer_pkg::PW_COUNT);
    wire pw_done = run && (mode == `MODE_PULSE) && pw_on && pw_stop;

    // count step; a count read freezes it, so that byte is never torn
    wire blk = rd_i && (hit_hi || hit_lo);
    wire step = (mode == `MODE_EVENT) ? ev_edge :
      (mode == `MODE_TIMER) ? tick :
      (mode == `MODE_PULSE) ? (pw_on && !pw_stop && tick) : 1'b0;
    assign inc_w[i] = run && step && !blk;
    assign top_w[i] = (count_reg[i] == TOP);

    // preload path: high byte write merges the buffered low byte
    wire ld_wr = wr_i && hit_hi;
    wire [15:0] ld_val = (i == 0) ? {8'h00, wdata_i} : {wdata_i, lowbuf_reg[i]};

    // next values
    wire [15:0] count_next = (ld_wr && !run) ? ld_val :
      !inc_w[i] ? count_reg[i] :
      top_w[i] ? preload_reg[i] : 16'(count_reg[i] + 16'h0001);
    wire [15:0] preload_next = ld_wr ? ld_val : preload_reg[i];
    wire [7:0] lowbuf_next = (wr_i && hit_lo) ? wdata_i :
      (rd_i && hit_hi && i != 0) ? count_reg[i][7:0] : lowbuf_reg[i];
    // a software write in the finishing cycle wins: it means a restart
    wire [7:0] ctrl_next = (wr_i && hit_ct) ? wdata_i :
      pw_done ? (ctrl_reg[i] & ~`CTRL_RUN_MASK) : ctrl_reg[i];
    wire [6:0] psc_next = !run ? 7'h00 :
      src ? 7'(psc_reg[i] + 7'h01) : psc_reg[i];
    wire pw_next_on = run && (mode == `MODE_PULSE) &&
      (pw_on ? !pw_stop : pw_start);
    timer_pkg::pw_state_t pw_next;
    assign pw_next = pw_next_on ? timer_pkg::PW_COUNT : timer_pkg::PW_WAIT;

    // read data of this counter; low byte comes from the buffer
    assign rd_val[i] = hit_hi ? ((i == 0) ? count_reg[i][7:0] : count_reg[i][15:8]) :
      hit_lo ? lowbuf_reg[i] : hit_ct ? ctrl_reg[i] : 8'h00;

    // counter state
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        count_reg[i] <= 16'h0000;
        preload_reg[i] <= 16'h0000;
        lowbuf_reg[i] <= 8'h00;
        ctrl_reg[i] <= `CTRL_RESET;
        psc_reg[i] <= 7'h00;
        pw_reg[i] <= timer_pkg::PW_WAIT;
        ovf_reg[i] <= 1'b0;
      end else begin
        count_reg[i] <= count_next;
        preload_reg[i] <= preload_next;
        lowbuf_reg[i] <= lowbuf_next;
        ctrl_reg[i] <= ctrl_next;
        psc_reg[i] <= psc_next;
        pw_reg[i] <= pw_next;
        ovf_reg[i] <= inc_w[i] && top_w[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port: data valid only in the cycle after the strobe
  wire [7:0] gc_val = gc_hit ? gc_reg : 8'h00;
  wire [7:0] rdata_next = rd_i ? (rd_val[0] | rd_val[1] | rd_val[2] | gc_val) : 8'h00;

  // read data flop
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flops
  assign rdata_o = rdata_reg;
  assign overflow_o = {ovf_reg[2], ovf_reg[1], ovf_reg[0]};

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  wire c0_wr = wr_i && (addr_i == `ADDR_C0_COUNT);
  wire c1_hi = (addr_i == `ADDR_C1_HIGH);
  wire c1_lo = (addr_i == `ADDR_C1_LOW);
  wire c2_hi = (addr_i == `ADDR_C2_HIGH);

  property p_c0_wrap;
    inc_w[0] && count_reg[0] == `TOP_8 && !c0_wr |=>
      count_reg[0] == $past(preload_reg[0]) && overflow_o[0];
  endproperty
  a_c0_wrap: assert property (p_c0_wrap)
    else $error("counter 0 did not reload at its 8-bit top");

  property p_c1_low_wr;
    wr_i && c1_lo |=> lowbuf_reg[1] == $past(wdata_i) && $stable(preload_reg[1]);
  endproperty
  a_c1_low_wr: assert property (p_c1_low_wr)
    else $error("low byte write touched more than the buffer");

  property p_c1_high_wr;
    wr_i && c1_hi |=> preload_reg[1] == {$past(wdata_i), $past(lowbuf_reg[1])};
  endproperty
  a_c1_high_wr: assert property (p_c1_high_wr)
    else $error("high byte write did not merge the buffered low byte");

  property p_c1_high_rd;
    rd_i && c1_hi |=> rdata_o == $past(count_reg[1][15:8]) &&
      lowbuf_reg[1] == $past(count_reg[1][7:0]);
  endproperty
  a_c1_high_rd: assert property (p_c1_high_rd)
    else $error("high byte read did not capture the low half");

  property p_c1_low_rd;
    rd_i && c1_lo |=> rdata_o == $past(lowbuf_reg[1]);
  endproperty
  a_c1_low_rd: assert property (p_c1_low_rd)
    else $error("low byte read did not return the buffer");

  property p_c2_pair;
    rd_i && c2_hi ##1 rd_i && addr_i == `ADDR_C2_LOW |=>
      rdata_o == $past(count_reg[2][7:0], 2);
  endproperty
  a_c2_pair: assert property (p_c2_pair)
    else $error("counter 2 byte pair read was not coherent");

  property p_unused;
    ctrl_reg[0][`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_UNUSED |-> !inc_w[0] ##1 !overflow_o[0];
  endproperty
  a_unused: assert property (p_unused)
    else $error("counter 0 counted in the unused mode");

  property p_off_hold;
    !ctrl_reg[1][`CTRL_RUN] && !(wr_i && c1_hi) |=> $stable(count_reg[1]);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("disabled counter 1 changed");

  property p_rd_block;
    rd_i && addr_i == `ADDR_C0_COUNT |-> !inc_w[0];
  endproperty
  a_rd_block: assert property (p_rd_block)
    else $error("counter 0 stepped during its read");

  property p_off_load;
    c0_wr && !ctrl_reg[0][`CTRL_RUN] |=> count_reg[0] == {8'h00, $past(wdata_i)};
  endproperty
  a_off_load: assert property (p_off_load)
    else $error("preload write did not load an idle counter");

  property p_pw_done;
    g_cnt[0].pw_done && !(wr_i && addr_i == `ADDR_C0_CTRL) |=>
      !ctrl_reg[0][`CTRL_RUN] && $stable(count_reg[0]);
  endproperty
  a_pw_done: assert property (p_pw_done)
    else $error("pulse measurement did not stop and hold");

  property p_div2;
    inc_w[0] && ctrl_reg[0] == 8'h91 |=> !inc_w[0];
  endproperty
  a_div2: assert property (p_div2)
    else $error("divide by two stepped on adjacent cycles");

  // a settled rising pin edge in event mode is one step, unless a read holds it
  property p_ev_rise;
    g_cnt[0].mode == `MODE_EVENT && g_cnt[0].run && !g_cnt[0].esel &&
      g_cnt[0].p_rise && !g_cnt[0].blk && count_reg[0] != `TOP_8 |=>
      count_reg[0] == 16'($past(count_reg[0]) + 16'h0001);
  endproperty
  a_ev_rise: assert property (p_ev_rise)
    else $error("counter 0 missed a rising pin edge");

  property p_c1_wrap;
    inc_w[1] && top_w[1] |=> count_reg[1] == $past(preload_reg[1]) && overflow_o[1];
  endproperty
  a_c1_wrap: assert property (p_c1_wrap)
    else $error("counter 1 did not reload at its 16-bit top");

  // an idle counter keeps a held pulse measurement until software loads it
  property p_off_hold0;
    !ctrl_reg[0][`CTRL_RUN] && !c0_wr |=> $stable(count_reg[0]);
  endproperty
  a_off_hold0: assert property (p_off_hold0)
    else $error("disabled counter 0 changed");

  property p_blk16;
    rd_i && (c1_hi || c1_lo) |-> !inc_w[1];
  endproperty
  a_blk16: assert property (p_blk16)
    else $error("counter 1 stepped during a count read");

  // main scenarios
  c_ovf0: cover property (overflow_o[0]);
  c_ovf1: cover property (overflow_o[1]);
  c_pw: cover property (g_cnt[0].pw_done);
  c_pair: cover property (rd_i && c1_hi ##1 rd_i && c1_lo);
  c_blk: cover property (rd_i && addr_i == `ADDR_C0_COUNT && g_cnt[0].run && g_cnt[0].step);

endmodule // triple_timer_event_counter

// ### test/pulse_source.sv
/*
 Far-side model: a signal source on the counter pins that sends a burst of
 equal high and low pulses on request.
 Assumes requests come one clock after a rising edge, by non-blocking update.
*/
`timescale 1ns/1ps

module pulse_source (
  input wire logic clk_sys_i,
  input wire logic go_i,
  input wire logic [3:0] count_i,
  input wire logic [7:0] width_i,
  output logic pin_o,
  output logic busy_o
);
  // pin idles low, which is a real level, so no release pattern is needed
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // width of at least three cycles keeps the device's edge filter honest
  always begin
    @(posedge clk_sys_i);
    if (go_i) begin
      busy_o <= 1'b1;
      repeat (count_i) begin
        pin_o <= 1'b1;
        repeat (width_i) @(posedge clk_sys_i);
        pin_o <= 1'b0;
        repeat (width_i) @(posedge clk_sys_i);
      end
      busy_o <= 1'b0;
    end
  end
endmodule // pulse_source

// ### test/triple_timer_event_counter_tb.sv
/*
 Self-checking bench of the triple timer/event counter: reset values,
 buffered count access, event, timer, pulse width and idle modes.
 Assumes the pulse_source model on the pins and slow clocks made here.
*/
`timescale 1ns/1ps

module triple_timer_event_counter_tb;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic rc_clk = 1'b0;
  logic xt_clk = 1'b0;
  logic tk_clk = 1'b0;
  logic tm_clk = 1'b0;
  logic [2:0] overflow_o;
  logic pulse_go = 1'b0;
  logic [3:0] pulse_n = 4'h0;
  logic [7:0] pulse_w = 8'h00;
  logic pulse_pin;
  logic pulse_busy;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int ovf_n = 0;

  ////////////////////////////////////////////////////////////////////////////
  // system clock 25 MHz; slow clocks toggle between system edges
  always #20 clk_sys_i = ~clk_sys_i;
  always #320 rc_clk = ~rc_clk;
  always #160 xt_clk = ~xt_clk;
  // touch clocks of 10 and 12 cycles; the module clock shares the crystal
  always #200 tk_clk = ~tk_clk;
  always #240 tm_clk = ~tm_clk;

  triple_timer_event_counter dut_u (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .internal_low_freq_rc_i(rc_clk),
    .external_low_freq_crystal_i(xt_clk),
    .touch_reference_clock_i(tk_clk),
    .touch_sense_clock_i(tm_clk),
    .touch_module_clock_i(xt_clk),
    .counter_pin_i({3{pulse_pin}}),
    .overflow_o(overflow_o)
  );

  pulse_source src_u (
    .clk_sys_i(clk_sys_i),
    .go_i(pulse_go),
    .count_i(pulse_n),
    .width_i(pulse_w),
    .pin_o(pulse_pin),
    .busy_o(pulse_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // overflow pulses of counter 0 and the hang guard
  always @(posedge clk_sys_i) begin
    if (overflow_o[0] === 1'b1) ovf_n <= ovf_n + 1;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails = fails + 1;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // register port: one-cycle strobes, a full cycle between accesses
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd_reg(a, d);
    check(what, {8'h00, d}, {8'h00, exp});
  endtask

  // high then low byte with no gap between the strobes
  task automatic rd_pair(input logic [7:0] hi, input logic [7:0] eh, input logic [7:0] el);
    @(posedge clk_sys_i);
    addr_i <= hi;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    addr_i <= hi + 8'h01;
    #1;
    check("pair high byte", {8'h00, rdata_o}, {8'h00, eh});
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    check("pair low byte", {8'h00, rdata_o}, {8'h00, el});
  endtask

  // burst from the pin model, then time for the edge filter to settle
  task automatic pulses(input logic [3:0] n, input logic [7:0] w);
    @(posedge clk_sys_i);
    pulse_go <= 1'b1;
    pulse_n <= n;
    pulse_w <= w;
    @(posedge clk_sys_i);
    pulse_go <= 1'b0;
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (!pulse_busy) break;
    end
    repeat (8) @(posedge clk_sys_i);
  endtask

  task automatic wait_ovf(input int idx, output int n);
    n = 0;
    while (n < 5000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
      if (overflow_o[idx] === 1'b1) break;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd_chk(8'h09, 8'h00, "general control");
    rd_chk(8'h0e, 8'h08, "control 0");
    rd_chk(8'h11, 8'h08, "control 1");
    rd_chk(8'h1c, 8'h08, "control 2");
    wr_reg(8'h20, 8'h5a);
    rd_chk(8'h20, 8'h00, "unmapped");
  endtask

  // buffered low byte, same for both wide counters
  task automatic t_buffer(input logic [7:0] hi);
    wr_reg(hi + 8'h01, 8'h34);
    wr_reg(hi, 8'h12);
    rd_chk(hi, 8'h12, "high byte");
    rd_chk(hi + 8'h01, 8'h34, "low byte");
    wr_reg(hi + 8'h01, 8'h56);
    rd_chk(hi, 8'h12, "high after low write");
    rd_chk(hi + 8'h01, 8'h34, "low snapped by high read");
    rd_pair(hi, 8'h12, 8'h34);
  endtask

  // two reads one free edge apart: the read cycles themselves must not count
  task automatic t_block();
    logic [7:0] a;
    logic [7:0] b;
    wr_reg(8'h0d, 8'h00);
    wr_reg(8'h0e, 8'h90);
    rd_reg(8'h0d, a);
    rd_reg(8'h0d, b);
    check("steps between reads", {8'h00, 8'(b - a)}, 16'h0001);
    wr_reg(8'h0e, 8'h08);
  endtask

  task automatic t_event();
    wr_reg(8'h0d, 8'h00);
    wr_reg(8'h0e, 8'h50);
    pulses(4'h5, 8'h04);
    rd_chk(8'h0d, 8'h05, "rising edge count");
    wr_reg(8'h0d, 8'h80);
    rd_chk(8'h0d, 8'h05, "count after running write");
    wr_reg(8'h0e, 8'h58);
    pulses(4'h2, 8'h04);
    rd_chk(8'h0d, 8'h07, "falling edge count");
    wr_reg(8'h0e, 8'h08);
    wr_reg(8'h0d, 8'hfe);
    rd_chk(8'h0d, 8'hfe, "stopped write loads count");
    ovf_n <= 0;
    wr_reg(8'h0e, 8'h50);
    pulses(4'h2, 8'h04);
    check("overflow pulses", ovf_n[15:0], 16'h0001);
    rd_chk(8'h0d, 8'hfe, "reloaded count");
    wr_reg(8'h0e, 8'h08);
  endtask

  // unused mode while enabled, and timer mode while disabled
  task automatic t_idle(input logic [7:0] ctl);
    wr_reg(8'h0d, 8'hff);
    ovf_n <= 0;
    wr_reg(8'h0e, ctl);
    repeat (40) @(posedge clk_sys_i);
    rd_chk(8'h0d, 8'hff, "idle count");
    check("idle overflow", ovf_n[15:0], 16'h0000);
    wr_reg(8'h0e, 8'h08);
  endtask

  // a steady count gives the tick rate as the gap between overflows
  task automatic t_period(input int idx, input logic [7:0] ca, input logic [15:0] pre,
                          input logic [7:0] ctl, input logic [7:0] gc, input int exp);
    int n;
    wr_reg(8'h09, gc);
    wr_reg(ca - 8'h01, pre[7:0]);
    if (idx != 0) wr_reg(ca - 8'h02, pre[15:8]);
    wr_reg(ca, ctl);
    wait_ovf(idx, n);
    wait_ovf(idx, n);
    check("overflow period", n[15:0], exp[15:0]);
    wr_reg(ca, 8'h08);
  endtask

  // a 20-cycle high level measured once, then held
  task automatic t_pulse();
    logic [7:0] d;
    wr_reg(8'h0d, 8'h00);
    wr_reg(8'h0e, 8'hd8);
    pulses(4'h1, 8'h14);
    rd_reg(8'h0d, d);
    check("pulse width near 20", {15'h0000, d >= 8'h13 && d <= 8'h15}, 16'h0001);
    rd_chk(8'h0e, 8'hc8, "enable cleared");
    pulses(4'h1, 8'h1e);
    rd_chk(8'h0d, d, "measurement held");
    wr_reg(8'h0e, 8'h08);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_buffer(8'h0f);
    t_buffer(8'h1a);
    t_event();
    t_idle(8'h10);
    t_idle(8'h80);
    t_block();
    for (int p = 0; p < 8; p++) t_period(0, 8'h0e, 16'h00f0, 8'h90 | p[7:0], 8'h00, 16 << p);
    t_period(0, 8'h0e, 16'h00fc, 8'hb0, 8'h00, 64);
    t_period(0, 8'h0e, 16'h00fc, 8'hb0, 8'h01, 32);
    t_period(1, 8'h11, 16'hfff0, 8'h90, 8'h00, 64);
    t_period(1, 8'h11, 16'hfffc, 8'hb0, 8'h00, 64);
    t_period(2, 8'h1c, 16'hfff0, 8'h90, 8'h00, 64);
    t_period(2, 8'h1c, 16'hfffc, 8'hb0, 8'h00, 64);
    t_period(2, 8'h1c, 16'hfffc, 8'hb0, 8'h02, 40);
    t_period(2, 8'h1c, 16'hfffc, 8'hb0, 8'h04, 48);
    t_period(2, 8'h1c, 16'hfffc, 8'hb0, 8'h06, 32);
    t_pulse();
    final_report();
  end
endmodule // triple_timer_event_counter_tb
